// ---- verif/testbench.sv ----
// Self-checking bench for the serial port front end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        i_sys_clk;
   logic        i_nrst;
   logic [15:0] i_io_addr;
   logic        i_io_rd;
   logic        i_io_wr;
   logic [15:0] i_io_wdata;
   logic [15:0] o_io_rdata;
   logic        i_rx;
   logic        i_rx_tick16;
   logic        o_tx;
   logic        o_irq;
   logic [15:0] o_baud_divisor;
   int          bad_count;
   int          compares;

   uarf_top u_uarf_top (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_io_addr(i_io_addr),
      .i_io_rd(i_io_rd), .i_io_wr(i_io_wr), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
      .i_rx(i_rx), .i_rx_tick16(i_rx_tick16), .o_tx(o_tx), .o_irq(o_irq),
      .o_baud_divisor(o_baud_divisor));
   uarf_serial_peer u_uarf_serial_peer (.i_tx(o_tx), .o_rx(i_rx), .o_tick16(i_rx_tick16));

   initial
   begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end

   task automatic wrap_up;
      if (bad_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One strobe cycle; an idle cycle always separates two calls
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge i_sys_clk);
      i_io_addr = a;
      i_io_wdata = d;
      i_io_wr = 1'b1;
      @(negedge i_sys_clk);
      i_io_wr = 1'b0;
   endtask

   task automatic rc(input logic [15:0] a, input logic [15:0] exp, input string what);
      @(negedge i_sys_clk);
      i_io_addr = a;
      i_io_rd = 1'b1;
      @(negedge i_sys_clk);
      i_io_rd = 1'b0;
      chk(what, exp, o_io_rdata);
   endtask

   // Bounded waits; running out counts a mismatch and ends the run
   task automatic wait_irq(input logic lvl);
      int n;
      n = 0;
      while (o_irq !== lvl && n < 30000)
      begin
         @(negedge i_sys_clk);
         n++;
      end
      chk("irq", 16'(lvl), 16'(o_irq));
      if (o_irq !== lvl)
         wrap_up();
   endtask

   task automatic wait_rx(input int cnt);
      int n;
      n = 0;
      while (u_uarf_serial_peer.got_q.size() < cnt && n < 30000)
      begin
         @(negedge i_sys_clk);
         n++;
      end
      chk("tx count", 16'(cnt), 16'(u_uarf_serial_peer.got_q.size()));
      if (u_uarf_serial_peer.got_q.size() < cnt)
         wrap_up();
   endtask

   task automatic t_reset;
      rc(16'h0002, 16'h0001, "ident");
      rc(16'h0005, 16'h0060, "line status");
      rc(16'h0001, 16'h0000, "enables");
      rc(16'h00A0, 16'h0000, "unmapped");
      chk("tx idle", 16'h0001, 16'(o_tx));
   endtask

   task automatic t_divisor;
      wr(16'h0003, 16'h0080);
      wr(16'h0000, 16'hAB55);
      wr(16'h0001, 16'hCD12);
      rc(16'h0000, 16'h0055, "div low shared");
      rc(16'h0001, 16'h0012, "div high shared");
      wr(16'h0002, 16'h0009);
      rc(16'h0002, 16'h00C1, "ident selector set");
      wr(16'h0002, 16'h0008);
      wr(16'h0003, 16'h0003);
      rc(16'h0003, 16'h0003, "line control");
      chk("divisor", 16'h1255, o_baud_divisor);
      wr(16'h0007, 16'h0034);
      wr(16'h0008, 16'h0056);
      rc(16'h0007, 16'h0034, "div low dedicated");
      rc(16'h0008, 16'h0056, "div high dedicated");
      wr(16'h0001, 16'hF003);
      rc(16'h0001, 16'h0003, "enables");
      chk("divisor", 16'h5634, o_baud_divisor);
      wr(16'h0006, 16'h005A);
      rc(16'h0006, 16'h005A, "scratch");
      wr(16'h0001, 16'h0000);
   endtask

   // Single character stages; configured only while the line is idle
   task automatic t_nonfifo;
      wr(16'h0001, 16'h0001);
      u_uarf_serial_peer.send_byte(8'hA5);
      wait_irq(1'b1);
      rc(16'h0000, 16'h00A5, "rx char");
      chk("irq after read", 16'h0000, 16'(o_irq));
      u_uarf_serial_peer.send_byte(8'h11);
      u_uarf_serial_peer.send_byte(8'h22);
      rc(16'h0005, 16'h0063, "overrun status");
      rc(16'h0000, 16'h0011, "rx char kept");
      rc(16'h0005, 16'h0060, "status cleared");
      wr(16'h0001, 16'h0002);
      wait_irq(1'b1);
      wr(16'h0000, 16'h013C);
      wait_rx(1);
      chk("tx char", 16'h003C, {8'h00, u_uarf_serial_peer.got_q[0]});
      u_uarf_serial_peer.got_q.delete();
      wait_irq(1'b1);
   endtask

   task automatic t_fifo;
      wr(16'h0002, 16'h00C9);
      rc(16'h0002, 16'h00C2, "ident fifo");
      wr(16'h0001, 16'h0001);
      for (int i = 0; i < 13; i++)
         u_uarf_serial_peer.send_byte(8'h40 + 8'(i));
      chk("irq below trigger", 16'h0000, 16'(o_irq));
      for (int i = 13; i < 17; i++)
         u_uarf_serial_peer.send_byte(8'h40 + 8'(i));
      chk("irq at trigger", 16'h0001, 16'(o_irq));
      rc(16'h0005, 16'h0063, "rx fifo full");
      for (int i = 0; i < 16; i++)
      begin
         rc(16'h0000, 16'h0040 + 16'(i), "rx fifo char");
         if (i == 2)
            chk("irq under trigger", 16'h0000, 16'(o_irq));
      end
      wr(16'h0001, 16'h0002);
      wait_irq(1'b1);
      // Back to back writes; the eighteenth finds the buffer full
      @(negedge i_sys_clk);
      i_io_wr = 1'b1;
      i_io_addr = 16'h0000;
      for (int i = 0; i < 18; i++)
      begin
         if (i == 1)
            chk("irq after load", 16'h0000, 16'(o_irq));
         i_io_wdata = 16'h0060 + 16'(i);
         @(negedge i_sys_clk);
      end
      i_io_wr = 1'b0;
      wait_rx(17);
      repeat (1000) @(negedge i_sys_clk);
      chk("tx total", 16'd17, 16'(u_uarf_serial_peer.got_q.size()));
      for (int i = 0; i < 17; i++)
         chk("tx fifo char", 16'h0060 + 16'(i), {8'h00, u_uarf_serial_peer.got_q[i]});
      wait_irq(1'b1);
   endtask

   initial
   begin
      i_nrst = 1'b0;
      i_io_addr = 16'h0000;
      i_io_rd = 1'b0;
      i_io_wr = 1'b0;
      i_io_wdata = 16'h0000;
      bad_count = 0;
      compares = 0;
      repeat (3) @(negedge i_sys_clk);
      i_nrst = 1'b1;
      t_reset();
      t_divisor();
      t_nonfifo();
      t_fifo();
      @(negedge i_sys_clk);
      i_nrst = 1'b0;
      repeat (3) @(negedge i_sys_clk);
      i_nrst = 1'b1;
      t_reset();
      wrap_up();
   end
endmodule

// ---- verif/uarf_checker.sv ----
// Concurrent checks on the serial port front end top ports
module uarf_checker (
   input wire logic        i_sys_clk,
   input wire logic        i_nrst,
   input wire logic [15:0] i_io_addr,
   input wire logic        i_io_rd,
   input wire logic        i_io_wr,
   input wire logic [15:0] i_io_wdata,
   input wire logic [15:0] o_io_rdata,
   input wire logic        i_rx,
   input wire logic        i_rx_tick16,
   input wire logic        o_tx,
   input wire logic        o_irq,
   input wire logic [15:0] o_baud_divisor
);
   typedef struct packed {logic divisor_access_select; logic fifo; logic [3:0] ier;} uarf_shadow_t;
   uarf_shadow_t sh;
   uarf_shadow_t next_sh;

   // Mirror what software wrote; only writes change it, never the design's outputs
   always_comb
   begin
      next_sh = sh;
      if (i_io_wr && i_io_addr == 16'h0003)
         next_sh.divisor_access_select = i_io_wdata[7];
      if (i_io_wr && i_io_addr == 16'h0002)
         next_sh.fifo = i_io_wdata[0];
      if (i_io_wr && i_io_addr == 16'h0001 && !sh.divisor_access_select)
         next_sh.ier = i_io_wdata[3:0];
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         sh <= '0;
      else
         sh <= next_sh;
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);

   a_rdata_idle_zero: assert property (!i_io_rd |=> o_io_rdata == 16'h0000)
      else $error("read data not zero outside read");
   a_rdata_upper_zero: assert property (i_io_rd && i_io_addr == 16'h0000 |=> o_io_rdata[15:8] == 8'h00)
      else $error("upper byte of data read not zero");
   a_divlow_shared_wr: assert property (i_io_wr && i_io_addr == 16'h0000 && sh.divisor_access_select
      |=> o_baud_divisor[7:0] == $past(i_io_wdata[7:0]))
      else $error("shared write missed divisor low");
   a_divlow_shared_rd: assert property (i_io_rd && i_io_addr == 16'h0000 && sh.divisor_access_select
      |=> o_io_rdata == {8'h00, o_baud_divisor[7:0]})
      else $error("shared read missed divisor low");
   a_divhigh_shared_rd: assert property (i_io_rd && i_io_addr == 16'h0001 && sh.divisor_access_select
      |=> o_io_rdata == {8'h00, o_baud_divisor[15:8]})
      else $error("shared read missed divisor high");
   a_enables_read: assert property (i_io_rd && i_io_addr == 16'h0001 && !sh.divisor_access_select
      |=> o_io_rdata == {12'h000, sh.ier})
      else $error("enables read back wrong");
   a_divlow_dedicated: assert property (i_io_wr && i_io_addr == 16'h0007
      |=> o_baud_divisor[7:0] == $past(i_io_wdata[7:0]))
      else $error("dedicated divisor low write lost");
   a_divhigh_dedicated: assert property (i_io_wr && i_io_addr == 16'h0008
      |=> o_baud_divisor[15:8] == $past(i_io_wdata[7:0]))
      else $error("dedicated divisor high write lost");
   a_divisor_hold: assert property (!i_io_wr |=> $stable(o_baud_divisor))
      else $error("divisor changed without a write");
   a_fifo_status_field: assert property (i_io_rd && i_io_addr == 16'h0002
      |=> o_io_rdata[7:6] == (sh.fifo ? 2'h3 : 2'h0))
      else $error("fifo status field wrong");
   a_irq_needs_enable: assert property (sh.ier[1:0] == 2'h0 |-> !o_irq)
      else $error("interrupt without enable");
   a_tx_bit_width: assert property ($changed(o_tx) |=> $stable(o_tx) [*7])
      else $error("transmit bit too short");

   c_irq_rise: cover property ($rose(o_irq));
   c_tx_start: cover property ($fell(o_tx));
   c_fifo_ident: cover property (i_io_rd && i_io_addr == 16'h0002 && sh.fifo);
endmodule

bind uarf_top uarf_checker u_uarf_checker (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
   .i_io_addr(i_io_addr), .i_io_rd(i_io_rd), .i_io_wr(i_io_wr), .i_io_wdata(i_io_wdata),
   .o_io_rdata(o_io_rdata), .i_rx(i_rx), .i_rx_tick16(i_rx_tick16), .o_tx(o_tx),
   .o_irq(o_irq), .o_baud_divisor(o_baud_divisor));

// ---- verif/uarf_serial_peer.sv ----
// Far-side serial device: drives the receive pin and the 16x tick, decodes transmit
module uarf_serial_peer (
   input  wire logic i_tx,
   output      logic o_rx,
   output      logic o_tick16
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] got_q[$];

   // Free running tick, phase unrelated to the system clock
   initial
   begin
      o_rx = 1'b1;
      o_tick16 = 1'b0;
      #3;
      forever #20 o_tick16 = ~o_tick16;
   end

   task automatic ticks(input int n);
      repeat (n) @(posedge o_tick16);
   endtask

   // 8N1 frame, low bit first, sixteen ticks per bit
   task automatic send_byte(input logic [7:0] b);
      o_rx = 1'b0;
      ticks(16);
      for (int i = 0; i < 8; i++)
      begin
         o_rx = b[i];
         ticks(16);
      end
      o_rx = 1'b1;
      ticks(16);
   endtask

   // Sample mid bit; a frame with a low stop bit is dropped
   initial
   begin : rx_loop
      logic [7:0] v;
      forever
      begin
         @(negedge i_tx);
         ticks(8);
         for (int i = 0; i < 8; i++)
         begin
            ticks(16);
            v[i] = i_tx;
         end
         ticks(16);
         if (i_tx === 1'b1)
            got_q.push_back(v);
      end
   end
endmodule

// ---- verilog/uarf_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides
module uarf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             i_sys_clk,
   input  wire logic             i_nrst,
   input  wire logic             i_flush,
   input  wire logic             i_in_valid,
   output      logic             o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output      logic             o_out_valid,
   input  wire logic             i_out_ready,
   output      logic [WIDTH-1:0] o_out_data,
   output      logic [$clog2(DEPTH):0] o_count
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0]   cnt;
   } uarf_fifo_t;
   uarf_fifo_t st;
   uarf_fifo_t next_st;
   logic [WIDTH-1:0] mem [DEPTH];  // Contents survive reset on purpose
   logic push;
   logic pop;

   assign o_in_ready  = (st.cnt != (AW+1)'(DEPTH));
   assign o_out_valid = (st.cnt != '0);
   assign o_out_data  = mem[st.rd];
   assign o_count     = st.cnt;
   assign push = i_in_valid & o_in_ready;
   assign pop  = o_out_valid & i_out_ready;

   // Pointer and count update; flush clears pointers and count, not storage
   always_comb
   begin
      next_st = st;
      if (i_flush)
      begin
         next_st = '0;
      end
      else
      begin
         if (push)
            next_st.wr = st.wr + 1'b1;
         if (pop)
            next_st.rd = st.rd + 1'b1;
         next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         st <= '0;
      else
         st <= next_st;
   end

   // Storage has no reset so held characters keep their value
   always_ff @(posedge i_sys_clk)
   begin
      if (push && !i_flush)
         mem[st.wr] <= i_in_data;
   end
endmodule

// ---- verilog/uarf_pkg.sv ----
// Package for the serial port register front end: offsets, fields, states, timing
package uarf_pkg;
   // Register offsets (word index in I/O space)
   localparam logic [2:0] ADDR_SHARED0  = 3'h0;   // rx buffer / tx holding / divisor low
   localparam logic [2:0] ADDR_SHARED1  = 3'h1;   // interrupt enables / divisor high
   localparam logic [2:0] ADDR_SHARED2  = 3'h2;   // identification (rd) / fifo control (wr)
   localparam logic [2:0] ADDR_LINE_CTL = 3'h3;
   localparam logic [2:0] ADDR_MODEM    = 3'h4;
   localparam logic [2:0] ADDR_LINE_ST  = 3'h5;
   localparam logic [2:0] ADDR_SCRATCH  = 3'h6;
   localparam logic [2:0] ADDR_DIV_LOW  = 3'h7;
   localparam logic [3:0] ADDR_DIV_HIGH = 4'h8;
   localparam logic [3:0] ADDR_PWR_EMU  = 4'h9;

   // Field positions
   localparam int LCR_DIVISOR_ACCESS_SELECT_BIT   = 7;
   localparam int FCR_FIFO_EN    = 0;
   localparam int FCR_RX_RESET   = 1;
   localparam int FCR_TX_RESET   = 2;
   localparam int FCR_DMA_MODE   = 3;
   localparam int IER_RX_BIT     = 0;
   localparam int IER_TX_BIT     = 1;
   localparam int IER_USED_MASK  = 3;  // Bits 3..0 stored

   // Identification codes and reset values
   localparam logic [7:0] IIR_NONE   = 8'h01;
   localparam logic [1:0] FIFO_STAT_ON  = 2'h3;
   localparam logic [1:0] FIFO_STAT_OFF = 2'h0;
   localparam logic [2:0] IID_RX_READY  = 3'h2;
   localparam logic [2:0] IID_TX_EMPTY  = 3'h1;
   localparam logic [2:0] IID_NONE      = 3'h0;
   localparam logic [15:0] PECR_RESET   = 16'h0002;

   // Data path
   localparam int CHAR_W      = 8;
   localparam int FIFO_DEPTH  = 16;
   localparam int OVERSAMPLE  = 16;
   localparam logic [3:0] SAMPLE_MID  = 4'h7;
   localparam logic [3:0] SAMPLE_LAST = 4'hF;

   typedef enum logic [1:0] {UARF_IDLE, UARF_START, UARF_DATA, UARF_STOP} uarf_line_t;
endpackage

// ---- verilog/uarf_top.sv ----
// Serial port register front end: address decode, receive and transmit buffer paths
//
// Contract
// - Selector 0: shared address 0 reads receive buffer, writes transmit holding.
// - Selector 1: shared address 0 reads and writes the divisor low byte.
// - Shared address 1 reaches interrupt enables (selector 0) or divisor high (1).
// - Shared address 2 reads identification, writes fifo control, selector ignored.
// - Divisor bytes also reachable at dedicated addresses regardless of selector.
// - All registers sit at 16-bit addresses in processor I/O space.
// - Character in bits 7..0; bits 15..8 read zero, writes ignored.
// - With fifo mode the receive buffer is a 16-byte FIFO.
// - With fifo mode the transmit holding register is a 16-byte FIFO.
// - Receiver samples the line with a clock at sixteen times the bit rate.
// - Receive shift register assembles characters and moves them into buffer or FIFO.
// - Non-fifo: data-ready interrupt while a character waits; cleared on read.
// - Fifo: data-ready interrupt while occupancy is at or above trigger level.
// - Idle transmit shift register takes next character and serializes it out.
// - Non-fifo: holding-empty interrupt while holding is empty; cleared by a write.
// - Fifo: holding-empty interrupt when FIFO empty; cleared on first byte written.
// - Buffer character contents are not forced by reset.
// - Fifo mode follows fifo enable bit; identification reports 11b or 00b.
module uarf_top (
   input  wire logic        i_sys_clk,
   input  wire logic        i_nrst,
   input  wire logic [15:0] i_io_addr,
   input  wire logic        i_io_rd,
   input  wire logic        i_io_wr,
   input  wire logic [15:0] i_io_wdata,
   output      logic [15:0] o_io_rdata,
   input  wire logic        i_rx,
   input  wire logic        i_rx_tick16,
   output      logic        o_tx,
   output      logic        o_irq,
   output      logic [15:0] o_baud_divisor
);
   localparam int CW = uarf_pkg::CHAR_W;
   localparam int DP = uarf_pkg::FIFO_DEPTH;
   localparam int CNTW = $clog2(DP) + 1;

   typedef struct packed {
      logic [1:0]        rx_sync;
      logic [1:0]        tick_sync;
      logic              tick_prev;
      logic [7:0]        div_lo;
      logic [7:0]        div_hi;
      logic [3:0]        ier;
      logic [7:0]        fcr;
      logic [7:0]        lcr;
      logic [4:0]        mcr;
      logic [7:0]        scr;
      logic [15:0]       pecr;
      logic [15:0]       rdata;
      uarf_pkg::uarf_line_t rx_state;
      logic [3:0]        rx_ph;
      logic [2:0]        rx_bit;
      logic [CW-1:0]     rx_shift;
      uarf_pkg::uarf_line_t tx_state;
      logic [3:0]        tx_ph;
      logic [2:0]        tx_bit;
      logic [CW-1:0]     tx_shift;
      logic              tx_line;
      logic              overrun;
   } uarf_state_t;

   uarf_state_t st;
   uarf_state_t next_st;

   logic          fifo_mode;
   logic          divisor_access_select;
   logic          tick;
   logic          rx_in;
   logic          rx_push;
   logic          rx_pop;
   logic          rx_valid;
   logic [CW-1:0] rx_data;
   logic [CNTW-1:0] rx_cnt;
   logic          tx_push;
   logic          tx_pop;
   logic          tx_valid;
   logic [CW-1:0] tx_data;
   logic [CNTW-1:0] tx_cnt;
   logic [CNTW-1:0] rx_cap;
   logic [CNTW-1:0] tx_cap;
   logic [CNTW-1:0] trig;
   logic          rx_irq;
   logic          tx_irq;
   logic [7:0]    iir;
   logic [7:0]    lsr;
   logic          flush_rx;
   logic          flush_tx;

   // Single-character stage just caps the FIFO at one entry
   assign fifo_mode = st.fcr[uarf_pkg::FCR_FIFO_EN];
   assign divisor_access_select      = st.lcr[uarf_pkg::LCR_DIVISOR_ACCESS_SELECT_BIT];
   assign rx_cap    = fifo_mode ? CNTW'(DP) : CNTW'(1);
   assign tx_cap    = fifo_mode ? CNTW'(DP) : CNTW'(1);
   assign tick      = st.tick_sync[1] & ~st.tick_prev;
   assign rx_in     = st.rx_sync[1];
   assign o_tx           = st.tx_line;
   assign o_io_rdata     = st.rdata;
   assign o_baud_divisor = {st.div_hi, st.div_lo};

   // Trigger level from fifo control bits 7..6: 1, 4, 8, 14 bytes
   always_comb
   begin
      case (st.fcr[7:6])
         2'h0:    trig = CNTW'(1);
         2'h1:    trig = CNTW'(4);
         2'h2:    trig = CNTW'(8);
         default: trig = CNTW'(14);
      endcase
   end

   // Interrupt sources are levels derived from buffer occupancy, so no event is lost
   assign rx_irq = st.ier[uarf_pkg::IER_RX_BIT] &
                   (fifo_mode ? (rx_cnt >= trig)
                              : (rx_cnt != '0));
   assign tx_irq = st.ier[uarf_pkg::IER_TX_BIT] & (tx_cnt == '0);
   assign o_irq  = rx_irq | tx_irq;

   // Identification: receive outranks transmit; pending bit is active low
   always_comb
   begin
      iir = uarf_pkg::IIR_NONE;
      iir[7:6] = fifo_mode ? uarf_pkg::FIFO_STAT_ON : uarf_pkg::FIFO_STAT_OFF;
      if (rx_irq)
         iir[3:0] = {uarf_pkg::IID_RX_READY, 1'b0};
      else if (tx_irq)
         iir[3:0] = {uarf_pkg::IID_TX_EMPTY, 1'b0};
   end

   // Line status: data ready, overrun, holding empty, transmitter empty
   always_comb
   begin
      lsr = 8'h00;
      lsr[0] = rx_valid;
      lsr[1] = st.overrun;
      lsr[5] = (tx_cnt == '0);
      lsr[6] = (tx_cnt == '0) && (st.tx_state == uarf_pkg::UARF_IDLE);
   end

   // Bus decode strobes; reserved upper address bits must be zero
   assign rx_pop  = i_io_rd && (i_io_addr == 16'(uarf_pkg::ADDR_SHARED0)) && !divisor_access_select;
   assign tx_push = i_io_wr && (i_io_addr == 16'(uarf_pkg::ADDR_SHARED0)) && !divisor_access_select;
   assign rx_push = (st.rx_state == uarf_pkg::UARF_STOP) && tick &&
                    (st.rx_ph == uarf_pkg::SAMPLE_MID) && rx_in && (rx_cnt < rx_cap);
   assign tx_pop  = (st.tx_state == uarf_pkg::UARF_IDLE) && tx_valid;
   assign flush_rx = i_io_wr && (i_io_addr == 16'(uarf_pkg::ADDR_SHARED2)) &&
                     (i_io_wdata[uarf_pkg::FCR_RX_RESET] ||
                      i_io_wdata[uarf_pkg::FCR_FIFO_EN] != fifo_mode);
   assign flush_tx = i_io_wr && (i_io_addr == 16'(uarf_pkg::ADDR_SHARED2)) &&
                     (i_io_wdata[uarf_pkg::FCR_TX_RESET] ||
                      i_io_wdata[uarf_pkg::FCR_FIFO_EN] != fifo_mode);

   // Receive buffer path; occupancy against capacity gates the shift register hand-off
   // Occupancy, not the ready flag, limits the push so non-fifo mode caps at one
   uarf_fifo #(.WIDTH(CW), .DEPTH(DP)) u_rx_fifo (
      .i_sys_clk   (i_sys_clk),
      .i_nrst      (i_nrst),
      .i_flush     (flush_rx),
      .i_in_valid  (rx_push),
      .o_in_ready  (),
      .i_in_data   (st.rx_shift),
      .o_out_valid (rx_valid),
      .i_out_ready (rx_pop),
      .o_out_data  (rx_data),
      .o_count     (rx_cnt)
   );

   // Transmit holding path; writes beyond capacity are dropped
   // Ready is left open; the same capacity test guards the write strobe
   uarf_fifo #(.WIDTH(CW), .DEPTH(DP)) u_tx_fifo (
      .i_sys_clk   (i_sys_clk),
      .i_nrst      (i_nrst),
      .i_flush     (flush_tx),
      .i_in_valid  (tx_push && (tx_cnt < tx_cap)),
      .o_in_ready  (),
      .i_in_data   (i_io_wdata[7:0]),
      .o_out_valid (tx_valid),
      .i_out_ready (tx_pop),
      .o_out_data  (tx_data),
      .o_count     (tx_cnt)
   );

   // Register writes, read mux, receiver and transmitter machines
   always_comb
   begin
      next_st = st;
      next_st.rx_sync   = {st.rx_sync[0], i_rx};
      next_st.tick_sync = {st.tick_sync[0], i_rx_tick16};
      next_st.tick_prev = st.tick_sync[1];

      // Writes; upper data bits stored only at ADDR_PWR_EMU
      if (i_io_wr)
      begin
         case (i_io_addr)
            16'(uarf_pkg::ADDR_SHARED0):
               if (divisor_access_select)
                  next_st.div_lo = i_io_wdata[7:0];
            16'(uarf_pkg::ADDR_SHARED1):
               if (divisor_access_select)
                  next_st.div_hi = i_io_wdata[7:0];
               else
                  next_st.ier = i_io_wdata[uarf_pkg::IER_USED_MASK:0];
            16'(uarf_pkg::ADDR_SHARED2):
               next_st.fcr = i_io_wdata[7:0];
            16'(uarf_pkg::ADDR_LINE_CTL):
               next_st.lcr = i_io_wdata[7:0];
            16'(uarf_pkg::ADDR_MODEM):
               next_st.mcr = i_io_wdata[4:0];
            16'(uarf_pkg::ADDR_SCRATCH):
               next_st.scr = i_io_wdata[7:0];
            16'(uarf_pkg::ADDR_DIV_LOW):
               next_st.div_lo = i_io_wdata[7:0];
            16'(uarf_pkg::ADDR_DIV_HIGH):
               next_st.div_hi = i_io_wdata[7:0];
            16'(uarf_pkg::ADDR_PWR_EMU):
               next_st.pecr = i_io_wdata;
            default: ;
         endcase
      end

      // Read data registered; unmapped addresses answer zero
      next_st.rdata = 16'h0000;
      if (i_io_rd)
      begin
         case (i_io_addr)
            16'(uarf_pkg::ADDR_SHARED0):
               next_st.rdata = divisor_access_select ? {8'h00, st.div_lo} : {8'h00, rx_data};
            16'(uarf_pkg::ADDR_SHARED1):
               next_st.rdata = divisor_access_select ? {8'h00, st.div_hi} : {12'h000, st.ier};
            16'(uarf_pkg::ADDR_SHARED2):
               next_st.rdata = {8'h00, iir};
            16'(uarf_pkg::ADDR_LINE_CTL): next_st.rdata = {8'h00, st.lcr};
            16'(uarf_pkg::ADDR_MODEM):    next_st.rdata = {11'h000, st.mcr};
            16'(uarf_pkg::ADDR_LINE_ST):  next_st.rdata = {8'h00, lsr};
            16'(uarf_pkg::ADDR_SCRATCH):  next_st.rdata = {8'h00, st.scr};
            16'(uarf_pkg::ADDR_DIV_LOW):  next_st.rdata = {8'h00, st.div_lo};
            16'(uarf_pkg::ADDR_DIV_HIGH): next_st.rdata = {8'h00, st.div_hi};
            16'(uarf_pkg::ADDR_PWR_EMU):  next_st.rdata = st.pecr;
            default:                      next_st.rdata = 16'h0000;
         endcase
         if (i_io_addr == 16'(uarf_pkg::ADDR_LINE_ST))
            next_st.overrun = 1'b0;
      end

      // Receiver: 16 ticks per bit, sampled mid-bit, 8 data bits
      if (tick)
      begin
         next_st.rx_ph = st.rx_ph + 4'h1;
         case (st.rx_state)
            uarf_pkg::UARF_IDLE:
               if (!rx_in)
               begin
                  next_st.rx_state = uarf_pkg::UARF_START;
                  next_st.rx_ph = 4'h0;
               end
            uarf_pkg::UARF_START:
               if (st.rx_ph == uarf_pkg::SAMPLE_MID)
               begin
                  next_st.rx_ph = 4'h8;   // Realign so next sample lands mid-bit
                  next_st.rx_bit = 3'h0;
                  // A start bit gone high again by mid-bit is taken as a glitch
                  next_st.rx_state = rx_in ? uarf_pkg::UARF_IDLE : uarf_pkg::UARF_DATA;
               end
            uarf_pkg::UARF_DATA:
               if (st.rx_ph == uarf_pkg::SAMPLE_MID)
               begin
                  next_st.rx_shift = {rx_in, st.rx_shift[CW-1:1]};
                  next_st.rx_bit = st.rx_bit + 3'h1;
                  if (st.rx_bit == 3'h7)
                     next_st.rx_state = uarf_pkg::UARF_STOP;
               end
            uarf_pkg::UARF_STOP:
               if (st.rx_ph == uarf_pkg::SAMPLE_MID)
               begin
                  next_st.rx_state = uarf_pkg::UARF_IDLE;
                  // Full buffer: character dropped and overrun flagged, set beats clear
                  if (rx_in && (rx_cnt >= rx_cap))
                     next_st.overrun = 1'b1;
               end
            default: next_st.rx_state = uarf_pkg::UARF_IDLE;
         endcase
      end

      // Transmitter: bit timing from the same 16x tick, LSB first
      case (st.tx_state)
         uarf_pkg::UARF_IDLE:
            if (tx_pop)
            begin
               next_st.tx_shift = tx_data;
               next_st.tx_ph = 4'h0;
               next_st.tx_line = 1'b0;
               next_st.tx_state = uarf_pkg::UARF_START;
            end
         uarf_pkg::UARF_START:
            if (tick && st.tx_ph == uarf_pkg::SAMPLE_LAST)
            begin
               next_st.tx_line = st.tx_shift[0];
               next_st.tx_bit = 3'h0;
               next_st.tx_state = uarf_pkg::UARF_DATA;
            end
         uarf_pkg::UARF_DATA:
            if (tick && st.tx_ph == uarf_pkg::SAMPLE_LAST)
            begin
               next_st.tx_shift = {1'b0, st.tx_shift[CW-1:1]};
               next_st.tx_bit = st.tx_bit + 3'h1;
               next_st.tx_line = (st.tx_bit == 3'h7) ? 1'b1 : st.tx_shift[1];
               if (st.tx_bit == 3'h7)
                  next_st.tx_state = uarf_pkg::UARF_STOP;
            end
         uarf_pkg::UARF_STOP:
            if (tick && st.tx_ph == uarf_pkg::SAMPLE_LAST)
               next_st.tx_state = uarf_pkg::UARF_IDLE;
         default: next_st.tx_state = uarf_pkg::UARF_IDLE;
      endcase
      // Phase only runs inside a frame so every start bit lasts sixteen ticks
      if (tick && st.tx_state != uarf_pkg::UARF_IDLE)
         next_st.tx_ph = st.tx_ph + 4'h1;
   end

   // Whole state struct resets, divisor and scratch too, so software reloads them
   // FIFO storage has no reset, but FIFO pointers and count clear, so buffered characters are discarded
   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         st <= '0;
         st.rx_sync <= 2'h3;
         st.tx_line <= 1'b1;
         st.pecr <= uarf_pkg::PECR_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end
endmodule
